// File: core/lmsc_pkg.sv
// Purpose: Shared constants for the LED matrix scan core
// Assumes: 50 MHz reference clock, APB register access
// Notes: Summary of operation follows
// Summary of operation
// - Oscillator stays stopped after reset
// - Commons released, rows low after reset
// - Reset gives full dimming duty, blink off
// - Clock from internal 256 kHz or external
// - Disable stops clock and duty generator
// - External clock ignores disable, never powers down
// - Drive-off blanks rows and commons, duty generator keeps running; precedes disable
// - Address command loads the memory pointer
// - Pointer advances after each 4-bit word
// - Blink flashes whole display, divided clock
// - Static 88 by 4 memory, one lights
// - Row n uses words 2n and 2n+1
// - 44 by 8 scan, N or P commons
// - Row PWM dimming, 20-tick period
`default_nettype none
package lmsc_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SYS_HZ = 256_000;
    localparam int unsigned SYS_DIV = CLK_HZ / SYS_HZ;
    localparam int unsigned POR_QUIET_US = 1000;
    localparam int unsigned RAM_WORDS = 88;
    localparam logic [6:0] RAM_LAST = 7'h57;
    localparam int unsigned ROWS = 44;
    localparam int unsigned COMS = 8;
    localparam logic [8:0] SLOT_TICKS = 9'h148;
    localparam logic [4:0] DIM_PERIOD = 5'h14;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_ADDR = 12'h004;
    localparam logic [11:0] OFF_DATA = 12'h008;
    localparam logic [11:0] OFF_STAT = 12'h00c;
    localparam int unsigned CTRL_SYSEN = 0;
    localparam int unsigned CTRL_LEDON = 1;
    localparam int unsigned CTRL_EXTCLK = 2;
    localparam int unsigned CTRL_PMOS = 3;
    localparam int unsigned CTRL_BLINK = 4;
    localparam int unsigned CTRL_DIM = 8;
    localparam logic [3:0] DIM_RESET = 4'hf;
    localparam logic [1:0] BLINK_OFF = 2'h0;
    localparam logic [1:0] BLINK_2HZ = 2'h1;
    localparam logic [1:0] BLINK_1HZ = 2'h2;
    localparam int unsigned HALF_2HZ = SYS_HZ / 4;
    localparam int unsigned HALF_1HZ = SYS_HZ / 2;
    localparam int unsigned HALF_05HZ = SYS_HZ;

    // Row on-time in ticks for a dimming level, level 15 is full period
    function automatic logic [4:0] dimOnTicks(input logic [3:0] lvl);
        logic [9:0] p;
        p = 10'({6'h00, lvl} + 10'h001) * 10'(DIM_PERIOD);
        return p[8:4];
    endfunction
endpackage
`default_nettype wire

// File: core/lmsc_ram.sv
// Purpose: Display memory, one write port and two registered read ports
// Assumes: Addresses presented are below the word count
// Notes: Contents are not reset, like a static store
`timescale 1ns/1ps
`default_nettype none
module lmsc_ram import lmsc_pkg::*; (
    input wire logic clk,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [3:0] wdata,
    input wire logic [6:0] raddrA,
    output logic [3:0] rdataA,
    input wire logic [6:0] raddrB,
    output logic [3:0] rdataB
);
    logic [3:0] mem [RAM_WORDS];

    // Word store, a one bit lights its LED
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Scan port
    always_ff @(posedge clk) begin
        rdataA <= mem[raddrA];
    end

    // Bus port
    always_ff @(posedge clk) begin
        rdataB <= mem[raddrB];
    end
endmodule // lmsc_ram
`default_nettype wire

// File: core/lmsc_timebase.sv
// Purpose: Scan slot, dimming and blink timing on the system tick
// Assumes: tick is a one-cycle pulse per system clock period
// Notes: All counters clear while the time base is halted
`timescale 1ns/1ps
`default_nettype none
module lmsc_timebase import lmsc_pkg::*; #(
    parameter int unsigned BLINK_HALF_2HZ = HALF_2HZ,
    parameter int unsigned BLINK_HALF_1HZ = HALF_1HZ,
    parameter int unsigned BLINK_HALF_05HZ = HALF_05HZ
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic tick,
    input wire logic run,
    input wire logic [1:0] blinkSel,
    input wire logic [3:0] dimLevel,
    output logic [2:0] comIdx,
    output logic [8:0] slotCnt,
    output logic slotWrap,
    output logic pwmOn,
    output logic blinkDark
);
    logic [4:0] dimCnt_q;
    logic [17:0] blinkCnt_q;
    logic [17:0] blinkHalf;

    assign slotWrap = tick && (slotCnt == SLOT_TICKS - 9'h001);
    assign pwmOn = dimCnt_q < dimOnTicks(dimLevel);

    // Slot and common counters, one common per slot
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            slotCnt <= 9'h000;
            comIdx <= 3'h0;
        end else if (!run) begin
            slotCnt <= 9'h000;
            comIdx <= 3'h0;
        end else if (slotWrap) begin
            slotCnt <= 9'h000;
            comIdx <= comIdx + 3'h1;
        end else if (tick) begin
            slotCnt <= slotCnt + 9'h001;
        end
    end

    // Dimming period counter
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dimCnt_q <= 5'h00;
        end else if (!run) begin
            dimCnt_q <= 5'h00;
        end else if (tick) begin
            dimCnt_q <= (dimCnt_q == DIM_PERIOD - 5'h01) ? 5'h00 : dimCnt_q + 5'h01;
        end
    end

    // Half period of the selected blink rate
    always_comb begin
        unique case (blinkSel)
            BLINK_2HZ: blinkHalf = 18'(BLINK_HALF_2HZ);
            BLINK_1HZ: blinkHalf = 18'(BLINK_HALF_1HZ);
            default: blinkHalf = 18'(BLINK_HALF_05HZ);
        endcase
    end

    // Blink phase divided from the system tick
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            blinkCnt_q <= 18'h00000;
            blinkDark <= 1'b0;
        end else if (!run || blinkSel == BLINK_OFF) begin
            blinkCnt_q <= 18'h00000;
            blinkDark <= 1'b0;
        end else if (tick) begin
            if (blinkCnt_q >= blinkHalf - 18'h00001) begin
                blinkCnt_q <= 18'h00000;
                blinkDark <= !blinkDark;
            end else begin
                blinkCnt_q <= blinkCnt_q + 18'h00001;
            end
        end
    end
endmodule // lmsc_timebase
`default_nettype wire

// File: core/lmsc_core.sv
// Purpose: LED matrix scan core with APB register access
// Assumes: APB inputs synchronous to ref_clk, external clock input sampled
// Notes: Rows are fetched for the next common during the current slot
`timescale 1ns/1ps
`default_nettype none
module lmsc_core import lmsc_pkg::*; #(
    parameter int unsigned BLINK_HALF_2HZ = HALF_2HZ,
    parameter int unsigned BLINK_HALF_1HZ = HALF_1HZ,
    parameter int unsigned BLINK_HALF_05HZ = HALF_05HZ
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extClkIn,
    output logic [43:0] segmentRowLines,
    output logic [7:0] commonLinesOut,
    output logic [7:0] commonLinesOe
);
    typedef enum logic [2:0] {
        FS_IDLE = 3'b001,
        FS_READ = 3'b010,
        FS_WAIT = 3'b100
    } lmsc_fetch_t;

    logic [1:0] rstPipe_q;
    logic rstSyncN;
    logic sysEnable_q, ledOn_q, extClk_q, pmos_q;
    logic [1:0] blinkSel_q;
    logic [3:0] dimLevel_q;
    logic [6:0] ptr_q, ptrNext;
    logic [7:0] divCnt_q;
    logic extPrev_q;
    logic intTick, extTick, sysTick, tbRun, driveOn;
    logic [2:0] comIdx;
    logic [8:0] slotCnt;
    logic slotWrap, pwmOn, blinkDark;
    logic setupPh, accessDone, wrEn, rdDone;
    logic ctrlHit, addrHit, dataHit, statHit;
    logic dataWrite, addrWrite, addrBad;
    logic [3:0] ramBusData, ramScanData;
    lmsc_fetch_t fetchState_q;
    logic [5:0] fetchIdx_q, capIdx_q;
    logic [2:0] fetchCom_q;
    logic [1:0] capBit_q;
    logic capValid_q;
    logic [43:0] rowNext_q, rowLatch_q;

    // Register offset match
    function automatic logic regHit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe_q[1];

    // Bus decode
    assign setupPh = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign ctrlHit = regHit(paddr, OFF_CTRL);
    assign addrHit = regHit(paddr, OFF_ADDR);
    assign dataHit = regHit(paddr, OFF_DATA);
    assign statHit = regHit(paddr, OFF_STAT);
    assign addrBad = pwdata[31:7] != 25'h0000000 || pwdata[6:0] > RAM_LAST;
    assign wrEn = accessDone && pwrite && !pslverr;
    assign rdDone = accessDone && !pwrite && !pslverr;
    assign dataWrite = wrEn && dataHit;
    assign addrWrite = wrEn && addrHit;

    // One wait-free access phase, answer registered in the setup cycle
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPh;
            pslverr <= setupPh && (!(ctrlHit || addrHit || dataHit || statHit)
                || (addrHit && pwrite && addrBad));
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prdata <= 32'h00000000;
        end else if (setupPh && !pwrite) begin
            if (ctrlHit) begin
                prdata <= {20'h00000, dimLevel_q, 2'b00, blinkSel_q,
                    pmos_q, extClk_q, ledOn_q, sysEnable_q};
            end else if (addrHit) begin
                prdata <= {25'h0000000, ptr_q};
            end else if (dataHit) begin
                prdata <= {28'h0000000, ramBusData};
            end else if (statHit) begin
                prdata <= {26'h0000000, blinkDark, comIdx, driveOn, tbRun};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Control fields, dark and stopped after reset
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            sysEnable_q <= 1'b0;
            ledOn_q <= 1'b0;
            extClk_q <= 1'b0;
            pmos_q <= 1'b0;
            blinkSel_q <= BLINK_OFF;
            dimLevel_q <= DIM_RESET;
        end else if (wrEn && ctrlHit) begin
            sysEnable_q <= pwdata[CTRL_SYSEN];
            ledOn_q <= pwdata[CTRL_LEDON];
            extClk_q <= pwdata[CTRL_EXTCLK];
            pmos_q <= pwdata[CTRL_PMOS];
            blinkSel_q <= pwdata[CTRL_BLINK +: 2];
            dimLevel_q <= pwdata[CTRL_DIM +: 4];
        end
    end

    // Memory pointer, loaded by address write, stepped per data word
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            ptr_q <= 7'h00;
        end else if (addrWrite) begin
            ptr_q <= pwdata[6:0];
        end else if (dataWrite || (rdDone && dataHit)) begin
            ptr_q <= (ptr_q == RAM_LAST) ? 7'h00 : ptr_q + 7'h01;
        end
    end

    // Pointer as it stands after this edge; the bus read port follows it so
    // a read setup right after an access never returns the previous word
    assign ptrNext = addrWrite ? pwdata[6:0]
        : (dataWrite || (rdDone && dataHit)) ? ((ptr_q == RAM_LAST) ? 7'h00 : ptr_q + 7'h01)
        : ptr_q;

    // System tick from internal divider or external clock edge
    assign intTick = sysEnable_q && !extClk_q && divCnt_q == 8'(SYS_DIV - 1);
    assign extTick = extClk_q && extClkIn && !extPrev_q;
    assign sysTick = intTick || extTick;
    assign tbRun = sysEnable_q || extClk_q;
    assign driveOn = sysEnable_q && ledOn_q;

    // Internal oscillator, held stopped while disabled
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            divCnt_q <= 8'h00;
        end else if (!sysEnable_q || extClk_q) begin
            divCnt_q <= 8'h00;
        end else begin
            divCnt_q <= intTick ? 8'h00 : divCnt_q + 8'h01;
        end
    end

    // External clock edge detect
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            extPrev_q <= 1'b0;
        end else begin
            extPrev_q <= extClkIn;
        end
    end

    lmsc_ram uRam (
        .clk(ref_clk),
        .we(dataWrite),
        .waddr(ptr_q),
        .wdata(pwdata[3:0]),
        .raddrA({fetchIdx_q, fetchCom_q[2]}),
        .rdataA(ramScanData),
        .raddrB(ptrNext),
        .rdataB(ramBusData)
    );

    lmsc_timebase #(
        .BLINK_HALF_2HZ(BLINK_HALF_2HZ),
        .BLINK_HALF_1HZ(BLINK_HALF_1HZ),
        .BLINK_HALF_05HZ(BLINK_HALF_05HZ)
    ) uTimebase (
        .clk(ref_clk),
        .rstN(rstSyncN),
        .tick(sysTick),
        .run(tbRun),
        .blinkSel(blinkSel_q),
        .dimLevel(dimLevel_q),
        .comIdx(comIdx),
        .slotCnt(slotCnt),
        .slotWrap(slotWrap),
        .pwmOn(pwmOn),
        .blinkDark(blinkDark)
    );

    // Row fetch for the following common, started at each slot start
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            fetchState_q <= FS_IDLE;
            fetchIdx_q <= 6'h00;
            fetchCom_q <= 3'h0;
        end else begin
            unique case (fetchState_q)
                FS_IDLE: begin
                    if (tbRun && sysTick && slotCnt == 9'h000) begin
                        fetchState_q <= FS_READ;
                        fetchIdx_q <= 6'h00;
                        fetchCom_q <= comIdx + 3'h1;
                    end
                end
                FS_READ: begin
                    if (fetchIdx_q == 6'(ROWS - 1)) begin
                        fetchState_q <= FS_WAIT;
                    end else begin
                        fetchIdx_q <= fetchIdx_q + 6'h01;
                    end
                end
                FS_WAIT: begin
                    fetchState_q <= FS_IDLE;
                end
                default: begin
                    fetchState_q <= FS_IDLE;
                end
            endcase
        end
    end

    // Read data follows its address by one cycle
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            capValid_q <= 1'b0;
            capIdx_q <= 6'h00;
            capBit_q <= 2'h0;
        end else begin
            capValid_q <= fetchState_q == FS_READ;
            capIdx_q <= fetchIdx_q;
            capBit_q <= fetchCom_q[1:0];
        end
    end

    // Shadow rows: for common k, bit k%4 of word 2n+k/4, so word 2n or 2n+1
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rowNext_q <= 44'h00000000000;
        end else if (capValid_q) begin
            rowNext_q[capIdx_q] <= ramScanData[capBit_q];
        end
    end

    // Shadow rows take over with the new common
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rowLatch_q <= 44'h00000000000;
        end else if (!tbRun) begin
            rowLatch_q <= 44'h00000000000;
        end else if (slotWrap) begin
            rowLatch_q <= rowNext_q;
        end
    end

    // Pin drivers, commons released and rows low when not driving
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            segmentRowLines <= 44'h00000000000;
            commonLinesOut <= 8'h00;
            commonLinesOe <= 8'h00;
        end else begin
            segmentRowLines <= (driveOn && pwmOn && !blinkDark) ? rowLatch_q
                : 44'h00000000000;
            commonLinesOe <= driveOn ? (8'h01 << comIdx) : 8'h00;
            commonLinesOut <= pmos_q ? (8'h01 << comIdx) : 8'h00;
        end
    end

    // Checks
    logic rstSeen_q;
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rstSeen_q <= 1'b0;
        end else begin
            rstSeen_q <= 1'b1;
        end
    end

    reset_defaults_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        !rstSeen_q |-> !sysEnable_q && dimLevel_q == DIM_RESET && blinkSel_q == BLINK_OFF)
        else $error("control fields not at reset defaults");
    dark_when_off_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        !driveOn |=> segmentRowLines == 44'h00000000000 && commonLinesOe == 8'h00)
        else $error("display driven while drive is off");
    disable_stops_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        !sysEnable_q && !extClk_q |-> !sysTick ##1 slotCnt == 9'h000)
        else $error("time base runs while disabled");
    ext_keeps_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        extClk_q && extClkIn && !extPrev_q |=> slotCnt == (($past(slotCnt) == SLOT_TICKS - 9'h001)
            ? 9'h000 : $past(slotCnt) + 9'h001))
        else $error("external clock edge lost");
    ptr_load_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        addrWrite |=> ptr_q == $past(pwdata[6:0]))
        else $error("pointer not loaded");
    ptr_step_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        dataWrite |=> ptr_q == (($past(ptr_q) == RAM_LAST) ? 7'h00 : $past(ptr_q) + 7'h01))
        else $error("pointer did not advance");
    int_tick_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        sysEnable_q && !extClk_q && intTick |=> !intTick [*8])
        else $error("internal tick period too short");
    slot_step_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        slotWrap |=> comIdx == $past(comIdx) + 3'h1 && slotCnt == 9'h000)
        else $error("common did not step at slot end");
    full_duty_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        dimLevel_q == DIM_RESET |-> pwmOn)
        else $error("full duty not continuous");
    one_common_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        $onehot0(commonLinesOe))
        else $error("more than one common active");
    blink_off_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        blinkSel_q == BLINK_OFF |=> !blinkDark)
        else $error("blank phase with blink off");
    row_map_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        capValid_q |=> rowNext_q[$past(capIdx_q)] == $past(ramScanData[capBit_q]))
        else $error("row bit not taken from its word");

    blink_seen_c: cover property (@(posedge ref_clk) disable iff (!rstSyncN)
        blinkSel_q == BLINK_2HZ && $rose(blinkDark));
    ptr_wrap_c: cover property (@(posedge ref_clk) disable iff (!rstSyncN)
        dataWrite && ptr_q == RAM_LAST);
    pmos_ext_c: cover property (@(posedge ref_clk) disable iff (!rstSyncN)
        pmos_q && extClk_q && driveOn && slotWrap);
    int_dim_c: cover property (@(posedge ref_clk) disable iff (!rstSyncN)
        !extClk_q && intTick && pwmOn);
endmodule // lmsc_core
`default_nettype wire

// File: dv/lmsc_ext_clk_model.sv
// Purpose: External system clock source that feeds the scan core
// Assumes: Runs from the bench reference clock
// Notes: Output stands low while disabled, so no stray ticks arrive
`timescale 1ns/1ps
`default_nettype none
module lmsc_ext_clk_model #(
    parameter int unsigned HALF = 2
) (
    input wire logic clk,
    input wire logic en,
    output logic clkOut
);
    logic [7:0] cnt_q;
    // Square wave of two HALF phases only while enabled
    always_ff @(posedge clk) begin
        if (!en) begin
            cnt_q <= 8'h00;
            clkOut <= 1'b0;
        end else if (cnt_q == 8'(HALF - 1)) begin
            cnt_q <= 8'h00;
            clkOut <= ~clkOut;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // lmsc_ext_clk_model
`default_nettype wire

// File: dv/lmsc_core_bench.sv
// Purpose: Self-checking bench for the scan core over APB
// Assumes: External tick every 4 cycles, so one slot is 1312 cycles
// Notes: Blink half periods shortened to 8/16/32 ticks
`timescale 1ns/1ps
`default_nettype none
module lmsc_core_bench import lmsc_pkg::*;;
    logic ref_clk, rstn, psel, penable, pwrite, extEn, pready, pslverr, extClkIn, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [43:0] segmentRowLines;
    logic [7:0] commonLinesOut, commonLinesOe;
    int numErrors, checksDone, n, on;

    lmsc_core #(.BLINK_HALF_2HZ(8), .BLINK_HALF_1HZ(16), .BLINK_HALF_05HZ(32)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extClkIn(extClkIn), .segmentRowLines(segmentRowLines),
        .commonLinesOut(commonLinesOut), .commonLinesOe(commonLinesOe));
    lmsc_ext_clk_model #(.HALF(2)) extSrc (.clk(ref_clk), .en(extEn), .clkOut(extClkIn));

    // Clock of 20 ns period
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [3:0] pat(input int w);
        return 4'(w / 2 + (w % 2) * 5 + 1);
    endfunction

    // Row n for common k from bit k%4 of word 2n+k/4
    function automatic logic [43:0] expRows(input int k);
        logic [3:0] w;
        expRows = '0;
        for (int r = 0; r < 44; r++) begin
            w = pat(2 * r + k / 4);
            expRows[r] = w[k % 4];
        end
    endfunction

    task automatic chk(input logic [43:0] got, input logic [43:0] exp);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(44'(rd), 44'(exp));
    endtask

    // Wait for a given common (or any change when tgt is zero), then settle
    task automatic waitSlot(input logic [7:0] tgt, input int lim, output int c);
        logic [7:0] prev;
        prev = commonLinesOe;
        c = 0;
        while ((tgt == 8'h00 ? commonLinesOe === prev : commonLinesOe !== tgt) && c < lim) begin
            @(posedge ref_clk);
            c++;
        end
        chk(44'(c < lim), 44'h1);
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic cntOn(input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            @(posedge ref_clk);
            if (segmentRowLines !== 44'h0) c++;
        end
    endtask

    task automatic conclude;
        if (numErrors == 0 && checksDone > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (95000) @(posedge ref_clk);
        numErrors++;
        conclude();
    end

    initial begin
        {rstn, psel, penable, pwrite, extEn} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        numErrors = 0;
        checksDone = 0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (POR_QUIET_US * (CLK_HZ / 1_000_000)) @(posedge ref_clk);
        chk(segmentRowLines, 44'h0);
        chk(44'({commonLinesOe, commonLinesOut}), 44'h0);
        rdChk(OFF_CTRL, 32'h00000f00);
        rdChk(OFF_STAT, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(44'({err, rd}), 44'h100000000);
        apb(1'b1, OFF_ADDR, 32'h58);
        chk(44'(err), 44'h1);
        rdChk(OFF_ADDR, 32'h0);
        for (int w = 0; w < 88; w++) apb(1'b1, OFF_DATA, 32'(pat(w)));
        rdChk(OFF_ADDR, 32'h0);
        apb(1'b1, OFF_ADDR, 32'h56);
        rdChk(OFF_DATA, 32'(pat(86)));
        rdChk(OFF_DATA, 32'(pat(87)));
        rdChk(OFF_ADDR, 32'h0);
        // Scan through one full frame on the external tick
        extEn <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'hf07);
        waitSlot(8'h01, 15000, n);
        for (int k = 1; k <= 8; k++) begin
            waitSlot(8'(8'h01 << (k % 8)), 1400, n);
            if (k > 1) chk(44'(n + 8), 44'h520);
            chk(segmentRowLines, expRows(k % 8));
            chk(44'(commonLinesOut), 44'h0);
        end
        apb(1'b1, OFF_CTRL, 32'hf0f);
        waitSlot(8'h01, 12000, n);
        chk(44'(commonLinesOut), 44'h01);
        chk(segmentRowLines, expRows(0));
        // Dimming duty over five periods of 80 cycles
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFF_CTRL, 32'h007 | (32'(i * 7 + (i / 2)) << 8));
            waitSlot(8'h00, 1400, n);
            cntOn(400, on);
            chk(44'(on), 44'((((i * 7 + i / 2) + 1) * 20 / 16) * 20));
        end
        // Blink codes 1 to 3, dark time over one blink period
        for (int s = 1; s <= 3; s++) begin
            apb(1'b1, OFF_CTRL, 32'hf07 | (32'(s) << 4));
            waitSlot(8'h00, 1400, n);
            cntOn(64 << (s - 1), on);
            chk(44'((64 << (s - 1)) - on), 44'(32 << (s - 1)));
        end
        apb(1'b1, OFF_CTRL, 32'h005);
        repeat (4) @(posedge ref_clk);
        chk(segmentRowLines, 44'h0);
        chk(44'(commonLinesOe), 44'h0);
        rdChk(OFF_CTRL, 32'h005);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(44'(rd[1:0]), 44'h1);
        apb(1'b1, OFF_CTRL, 32'h004);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(44'(rd[1:0]), 44'h1);
        apb(1'b1, OFF_CTRL, 32'h003);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(44'(rd[1:0]), 44'h3);
        // Internal tick at level 0: one tick on in twenty
        repeat (200) @(posedge ref_clk);
        cntOn(20 * SYS_DIV, on);
        chk(44'(on), 44'(SYS_DIV));
        apb(1'b1, OFF_CTRL, 32'h002);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(44'(rd[0]), 44'h0);
        chk(44'(commonLinesOe), 44'h0);
        conclude();
    end
endmodule // lmsc_core_bench
`default_nettype wire
